// [verilog/irq_status_mask.v]
// Interrupt status, mask and collision position registers of the reader core.
// Assumes a byte register port from the host interface, same-clock protocol
// events and an asynchronous enable pin and RF field level.
`timescale 1ns/1ps
`include "irq_status_map.vh"
module irq_status_mask #(
    parameter POS_W = 10
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    input wire enable_in,
    // Register port
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    // Operating mode
    input wire nfc_mode_in,
    input wire emul_mode_in,
    input wire vicinity_in,
    input wire type_a_in,
    // Transmit and receive phases
    input wire tx_start_in,
    input wire tx_end_in,
    input wire rx_sof_in,
    input wire rx_end_in,
    // Protocol events
    input wire fifo_cross_in,
    input wire crc_err_in,
    input wire parity_err_in,
    input wire frame_err_in,
    input wire bit_start_in,
    input wire col_hit_in,
    input wire [POS_W-1:0] col_pos_in,
    input wire noresp_in,
    input wire sdd_done_in,
    input wire rf_level_in,
    input wire ca_done_in,
    input wire ca_fail_in,
    // Interrupt and phase status
    output wire irq_out,
    output wire decoder_en_out
);
    localparam PH_IDLE = 2'd0;
    localparam PH_TX = 2'd1;
    localparam PH_RX = 2'd2;

    function is_addr;
        input [7:0] a;
        input [7:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    reg [1:0] phase_q;
    reg [1:0] phase_d;
    reg [7:0] status_q;
    reg [7:0] status_d;
    reg [7:0] mask_q;
    reg [7:0] mask_d;
    reg [7:0] col_low_q;
    reg [7:0] col_low_d;
    reg irq_q;
    reg irq_d;
    reg pend_q;
    reg pend_d;
    reg no_crc_q;
    reg limit7_q;
    reg [7:0] set_v;
    reg [7:0] allow_v;
    wire en_sync;
    wire rf_change;
    wire col_over;
    wire rd_status = reg_rd_in && is_addr(reg_addr_in, `ADDR_IRQ_STATUS);
    wire rd_col = reg_rd_in && is_addr(reg_addr_in, `ADDR_COLL_POS);
    wire wr_proto = reg_wr_in && is_addr(reg_addr_in, `ADDR_PROTO_CTRL);
    wire reader = !nfc_mode_in && !emul_mode_in;

    // Enable pin is asynchronous; acts as reset once synchronised
    edge_pulse #(.BOTH(0)) u_en (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .level_in(enable_in),
        .sync_out(en_sync),
        .pulse_out()
    );
    edge_pulse #(.BOTH(1)) u_rf (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .level_in(rf_level_in),
        .sync_out(),
        .pulse_out(rf_change)
    );
    collision_counter #(.CW(4)) u_col (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .bit_start_in(bit_start_in),
        .hit_in(col_hit_in),
        .limit7_in(limit7_q),
        .over_out(col_over)
    );

    // Enable low clears like a reset, but only once synchronised
    wire clr_all = !en_sync;

    always @*
    begin
        phase_d = phase_q;
        case (phase_q)
            PH_IDLE:
            begin
                if (tx_start_in)
                    phase_d = PH_TX;
                else if (rx_sof_in)
                    phase_d = PH_RX;
            end
            PH_TX:
                if (tx_end_in)
                    phase_d = PH_IDLE;
            PH_RX:
                if (rx_end_in)
                    phase_d = PH_IDLE;
            default:
                phase_d = PH_IDLE;
        endcase
    end

    always @*
    begin
        set_v = 8'h00;
        set_v[`BIT_TX] = tx_start_in;
        set_v[`BIT_RX] = rx_sof_in && phase_q != PH_TX;
        set_v[`BIT_FIFO] = fifo_cross_in;
        if (reader)
        begin
            set_v[`BIT_ERR1] = crc_err_in && !no_crc_q;
            set_v[`BIT_ERR2] = parity_err_in && type_a_in;
            set_v[`BIT_ERR3] = frame_err_in;
            set_v[`BIT_COL] = col_over;
            set_v[`BIT_NORESP] = noresp_in && vicinity_in;
        end
        else
        begin
            set_v[`BIT_ERR1] = crc_err_in || parity_err_in || frame_err_in;
            set_v[`BIT_ERR2] = sdd_done_in;
            set_v[`BIT_ERR3] = rf_change;
            set_v[`BIT_COL] = nfc_mode_in && ca_done_in;
            set_v[`BIT_NORESP] = nfc_mode_in && ca_fail_in;
        end
        case (phase_q)
            PH_TX:
                allow_v = 8'hA0;
            PH_RX:
                allow_v = 8'h40;
            default:
                allow_v = 8'hFF;
        endcase
        set_v = set_v & allow_v;
    end

    // Set wins over a read clear, so an event in the same cycle as a status read is kept
    always @*
    begin
        status_d = status_q;
        if (rd_status)
            status_d = `STATUS_RESET;
        status_d = status_d | set_v;
        if (clr_all || wr_proto)
            status_d = `STATUS_RESET;
    end

    // Maskable events wait for the phase end; a masked event raises nothing, save bits 3:1 outside reader mode
    wire [7:0] maskable = set_v & {2'b00, mask_q[5:1], mask_q[0]};
    wire hit_now = |maskable[5:0] || (!reader && |set_v[3:1]);
    wire phase_end = (phase_q == PH_TX && tx_end_in) || (phase_q == PH_RX && rx_end_in);

    // Events inside a phase are held until the phase ends
    always @*
    begin
        pend_d = pend_q;
        irq_d = irq_q;
        if (phase_q != PH_IDLE && hit_now)
            pend_d = 1'b1;
        if (phase_end)
        begin
            irq_d = 1'b1;
            pend_d = 1'b0;
        end
        else if (phase_q == PH_IDLE && (hit_now || pend_q))
        begin
            irq_d = 1'b1;
            pend_d = 1'b0;
        end
        else if (rd_status)
            irq_d = 1'b0;
        if (clr_all || wr_proto)
        begin
            irq_d = 1'b0;
            pend_d = 1'b0;
        end
    end

    always @*
    begin
        mask_d = mask_q;
        col_low_d = col_low_q;
        // Bits 7:6 belong to the collision capture, not the host
        if (reg_wr_in && is_addr(reg_addr_in, `ADDR_IRQ_MASK))
            mask_d[5:0] = reg_wdata_in[5:0];
        if (rd_col)
            col_low_d = `COLL_POS_RESET;
        // Position only means something for reader errors and collisions
        if (reader && (col_over || set_v[`BIT_ERR1] || set_v[`BIT_ERR2] || set_v[`BIT_ERR3]))
        begin
            col_low_d = col_pos_in[7:0];
            mask_d[7:6] = col_pos_in[9:8];
        end
        if (clr_all)
        begin
            mask_d = `MASK_RESET;
            col_low_d = `COLL_POS_RESET;
        end
    end

    always @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            phase_q <= PH_IDLE;
            status_q <= `STATUS_RESET;
            mask_q <= `MASK_RESET;
            col_low_q <= `COLL_POS_RESET;
            irq_q <= 1'b0;
            pend_q <= 1'b0;
            no_crc_q <= 1'b0;
            limit7_q <= 1'b0;
        end
        else
        begin
            phase_q <= clr_all ? PH_IDLE : phase_d;
            status_q <= status_d;
            mask_q <= mask_d;
            col_low_q <= col_low_d;
            irq_q <= irq_d;
            pend_q <= pend_d;
            if (clr_all)
                no_crc_q <= 1'b0;
            else if (wr_proto)
                no_crc_q <= reg_wdata_in[`PROTO_NO_CRC_BIT];
            if (clr_all)
                limit7_q <= 1'b0;
            else if (reg_wr_in && is_addr(reg_addr_in, `ADDR_SPECIAL_FN))
                limit7_q <= reg_wdata_in[`SPECIAL_COL7_BIT];
        end
    end

    // Registered read data follows the address by one cycle
    always @(posedge clk_in)
    begin
        if (!rst_b_in)
            reg_rdata_out <= 8'h00;
        else if (is_addr(reg_addr_in, `ADDR_IRQ_STATUS))
            reg_rdata_out <= status_q;
        else if (is_addr(reg_addr_in, `ADDR_IRQ_MASK))
            reg_rdata_out <= mask_q;
        else if (is_addr(reg_addr_in, `ADDR_COLL_POS))
            reg_rdata_out <= col_low_q;
        else
            reg_rdata_out <= 8'h00;
    end

    assign irq_out = irq_q;
    // Decoder off while transmitting
    assign decoder_en_out = (phase_q != PH_TX);
endmodule

// [verilog/irq_status_map.vh]
// Register offsets, field positions and reset values of the interrupt status block.
// Assumes inclusion by the status block and its helpers only.
`ifndef IRQ_STATUS_MAP_VH
`define IRQ_STATUS_MAP_VH
`define ADDR_PROTO_CTRL 8'h01
`define ADDR_NORESP_TIME 8'h07
`define ADDR_IRQ_STATUS 8'h0C
`define ADDR_IRQ_MASK 8'h0D
`define ADDR_COLL_POS 8'h0E
`define ADDR_SPECIAL_FN 8'h10
`define ADDR_FIFO_LEVEL 8'h14
`define STATUS_RESET 8'h00
`define MASK_RESET 8'h3E
`define COLL_POS_RESET 8'h00
`define BIT_TX 7
`define BIT_RX 6
`define BIT_FIFO 5
`define BIT_ERR1 4
`define BIT_ERR2 3
`define BIT_ERR3 2
`define BIT_COL 1
`define BIT_NORESP 0
`define PROTO_NO_CRC_BIT 7
`define SPECIAL_COL7_BIT 0
`define COL_LIMIT_LO 4'h6
`define COL_LIMIT_HI 4'h7
`endif

// [verilog/edge_pulse.v]
// Two-flop synchroniser with a one-cycle pulse on either edge or the rising edge.
// Assumes an asynchronous input level and one system clock.
`timescale 1ns/1ps
module edge_pulse #(
    parameter BOTH = 0
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // Level in, pulse out
    input wire level_in,
    output wire sync_out,
    output wire pulse_out
);
    reg meta_q;
    reg sync_q;
    reg last_q;
    always @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            meta_q <= level_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    assign sync_out = sync_q;
    assign pulse_out = BOTH ? (sync_q ^ last_q) : (sync_q & ~last_q);
endmodule

// [verilog/collision_counter.v]
// Counts collisions within one bit period and flags when over the limit.
// Assumes bit_start and hit are same-clock one-cycle pulses.
`timescale 1ns/1ps
`include "irq_status_map.vh"
module collision_counter #(
    parameter CW = 4
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // Bit timing and collision hits
    input wire bit_start_in,
    input wire hit_in,
    input wire limit7_in,
    // Result
    output wire over_out
);
    reg [CW-1:0] count_q;
    reg [CW-1:0] count_d;
    always @*
    begin
        count_d = count_q;
        if (bit_start_in)
            count_d = {CW{1'b0}};
        else if (hit_in && count_q != {CW{1'b1}})
            count_d = count_q + {{(CW-1){1'b0}}, 1'b1};
    end
    always @(posedge clk_in)
    begin
        if (!rst_b_in)
            count_q <= {CW{1'b0}};
        else
            count_q <= count_d;
    end
    // Above 6 or above 7 within the current bit
    assign over_out = hit_in && !bit_start_in &&
        (count_q >= (limit7_in ? `COL_LIMIT_HI : `COL_LIMIT_LO));
endmodule

// [bench/irq_status_mask_checker.sv]
// Concurrent checks on the status block ports.
// Assumes one system clock and the host port of the bench.
`timescale 1ns/1ps
module irq_status_mask_checker (
    // Clock, reset and enable
    input logic clk_in, rst_b_in, enable_in,
    // Register port
    input logic reg_wr_in, reg_rd_in,
    input logic [7:0] reg_addr_in,
    input logic [7:0] reg_rdata_out,
    // Phases and outputs
    input logic tx_start_in, tx_end_in, rx_end_in, irq_out, decoder_en_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence tx_go;
        tx_start_in && reg_addr_in == 8'h0C && !reg_rd_in && !reg_wr_in;
    endsequence
    sequence hold_peek;
        reg_addr_in == 8'h0C && !reg_rd_in && !reg_wr_in;
    endsequence
    chk_tx_flag_set: assert property (tx_go ##1 hold_peek |=> reg_rdata_out[7])
        else $error("transmit flag missing");
    chk_tx_irq_end: assert property (tx_end_in && !decoder_en_out && !reg_wr_in
        |=> irq_out && decoder_en_out)
        else $error("no interrupt after transmit");
    chk_tx_no_early: assert property (!decoder_en_out && !tx_end_in && !irq_out
        |=> !irq_out)
        else $error("interrupt inside transmit");
    chk_decoder_off: assert property (tx_start_in && decoder_en_out && !reg_wr_in
        |=> !decoder_en_out)
        else $error("decoder left on");
    chk_rx_irq_end: assert property (rx_end_in && decoder_en_out && !reg_wr_in
        |=> irq_out)
        else $error("no interrupt after receive");
    chk_proto_clear: assert property (reg_wr_in && reg_addr_in == 8'h01 |=> !irq_out)
        else $error("protocol write kept interrupt");
    chk_irq_fall_cause: assert property (@(posedge clk_in) disable iff (!rst_b_in || !enable_in)
        $fell(irq_out) |-> ($past(reg_rd_in) && $past(reg_addr_in) == 8'h0C)
        || ($past(reg_wr_in) && $past(reg_addr_in) == 8'h01))
        else $error("interrupt fell without clear");
    chk_mask_reset: assert property ($rose(rst_b_in) ##3 (reg_addr_in == 8'h0D && !reg_wr_in)
        |=> reg_rdata_out == 8'h3E)
        else $error("mask reset value wrong");
endmodule
bind irq_status_mask irq_status_mask_checker irq_status_mask_checker_inst (.clk_in, .rst_b_in,
    .enable_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_rdata_out, .tx_start_in,
    .tx_end_in, .rx_end_in, .irq_out, .decoder_en_out);

// [bench/host_model.sv]
// Host side: one register access per call.
// Assumes a single calling process.
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire clk_in,
    // Register port
    output reg [7:0] reg_addr_out = 8'h0D,
    output reg [7:0] reg_wdata_out = 8'h00,
    output reg reg_wr_out = 1'b0,
    output reg reg_rd_out = 1'b0,
    input wire [7:0] reg_rdata_in
);
    task xfer(input [7:0] a, input [7:0] d, input w, input r, output [7:0] q);
        @(posedge clk_in);
        reg_addr_out <= a;
        // Idle data inverted so stale bytes never look valid
        reg_wdata_out <= w ? d : ~d;
        reg_wr_out <= w;
        reg_rd_out <= r;
        @(posedge clk_in);
        reg_wr_out <= 1'b0;
        reg_rd_out <= 1'b0;
        #1 q = reg_rdata_in;
    endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the status block.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module tb_top;
    reg clk_in = 1'b0;
    reg rst_b_in = 1'b0;
    reg enable_in = 1'b1;
    reg nfc = 1'b0, emul = 1'b0, vic = 1'b0, rf = 1'b0, ta = 1'b1;
    reg [13:0] ev = 14'h0000;
    reg [9:0] pos = 10'h2A5;
    wire [7:0] addr, wdata, rdata;
    wire wr, rd, irq, dec;
    reg [7:0] q;
    integer fails = 0, num_checks = 0, cyc = 0, i;
    always #10 clk_in = ~clk_in;
    host_model host_model_inst (.clk_in(clk_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));
    irq_status_mask irq_status_mask_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .enable_in(enable_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .nfc_mode_in(nfc), .emul_mode_in(emul),
        .vicinity_in(vic), .type_a_in(ta), .tx_start_in(ev[8]), .tx_end_in(ev[9]),
        .rx_sof_in(ev[10]), .rx_end_in(ev[11]), .fifo_cross_in(ev[0]), .crc_err_in(ev[1]),
        .parity_err_in(ev[2]), .frame_err_in(ev[3]), .bit_start_in(ev[12]),
        .col_hit_in(ev[13]), .col_pos_in(pos), .noresp_in(ev[4]), .sdd_done_in(ev[5]),
        .rf_level_in(rf), .ca_done_in(ev[6]), .ca_fail_in(ev[7]), .irq_out(irq),
        .decoder_en_out(dec));
    task chk(input [7:0] got, input [7:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rd_chk(input [7:0] a, input [7:0] exp, input r);
        host_model_inst.xfer(a, 8'h00, 1'b0, r, q);
        chk(q, exp);
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        host_model_inst.xfer(a, d, 1'b1, 1'b0, q);
    endtask
    task pulse(input [13:0] m);
        @(posedge clk_in);
        ev <= m;
        @(posedge clk_in);
        ev <= 14'h0000;
        #1;
    endtask
    task ci(input exp);
        #1 chk({7'h00, irq}, {7'h00, exp});
    endtask
    task t_def;
        rd_chk(8'h0C, 8'h00, 1);
        rd_chk(8'h0D, 8'h3E, 1);
        rd_chk(8'h0E, 8'h00, 1);
    endtask
    task t_tx;
        rd_chk(8'h0C, 8'h00, 0);
        pulse(14'h0100);
        chk({7'h00, dec}, 8'h00);
        pulse(14'h0003);
        rd_chk(8'h0C, 8'hA0, 0);
        ci(1'b0);
        pulse(14'h0200);
        ci(1'b1);
        rd_chk(8'h0C, 8'hA0, 1);
        ci(1'b0);
    endtask
    task t_rx;
        pulse(14'h0400);
        pulse(14'h0002);
        rd_chk(8'h0C, 8'h40, 0);
        ci(1'b0);
        pulse(14'h0800);
        ci(1'b1);
        rd_chk(8'h0C, 8'h40, 1);
    endtask
    task t_err;
        for (i = 0; i < 4; i = i + 1)
        begin
            pulse(14'h0001 << i);
            ci(1'b1);
            rd_chk(8'h0C, 8'h20 >> i, 1);
        end
    endtask
    task t_mask;
        wr_reg(8'h0D, 8'h00);
        pulse(14'h0001);
        ci(1'b0);
        rd_chk(8'h0C, 8'h20, 1);
        wr_reg(8'h0D, 8'h3E);
        pulse(14'h0010);
        rd_chk(8'h0C, 8'h00, 1);
        @(posedge clk_in);
        vic <= 1'b1;
        pulse(14'h0010);
        ci(1'b0);
        rd_chk(8'h0C, 8'h01, 1);
        wr_reg(8'h0D, 8'h3F);
        pulse(14'h0010);
        ci(1'b1);
        rd_chk(8'h0C, 8'h01, 1);
    endtask
    task t_col;
        rd_chk(8'h0E, 8'hA5, 1);
        @(posedge clk_in);
        pos <= 10'h15A;
        pulse(14'h1000);
        for (i = 0; i < 6; i = i + 1)
            pulse(14'h2000);
        rd_chk(8'h0C, 8'h00, 0);
        pulse(14'h2000);
        rd_chk(8'h0C, 8'h02, 1);
        rd_chk(8'h0D, 8'h7F, 1);
        rd_chk(8'h0E, 8'h5A, 1);
        rd_chk(8'h0E, 8'h00, 0);
        wr_reg(8'h10, 8'h01);
        pulse(14'h1000);
        for (i = 0; i < 7; i = i + 1)
            pulse(14'h2000);
        rd_chk(8'h0C, 8'h00, 0);
        pulse(14'h2000);
        rd_chk(8'h0C, 8'h02, 1);
        wr_reg(8'h10, 8'h00);
    endtask
    task t_nfc;
        @(posedge clk_in);
        nfc <= 1'b1;
        for (i = 0; i < 3; i = i + 1)
        begin
            pulse(14'h0020 << i);
            rd_chk(8'h0C, i == 0 ? 8'h08 : 8'h02 >> (i - 1), 1);
        end
        @(posedge clk_in);
        nfc <= 1'b0;
        emul <= 1'b1;
        for (i = 0; i < 2; i = i + 1)
        begin
            @(posedge clk_in);
            rf <= (i == 0);
            repeat (6) @(posedge clk_in);
            rd_chk(8'h0C, 8'h04, 1);
        end
        @(posedge clk_in);
        emul <= 1'b0;
    endtask
    task t_proto;
        wr_reg(8'h01, 8'h80);
        pulse(14'h0002);
        rd_chk(8'h0C, 8'h00, 1);
        @(posedge clk_in);
        ta <= 1'b0;
        pulse(14'h0004);
        rd_chk(8'h0C, 8'h00, 1);
        @(posedge clk_in);
        ta <= 1'b1;
        pulse(14'h0001);
        wr_reg(8'h01, 8'h00);
        ci(1'b0);
        rd_chk(8'h0C, 8'h00, 1);
    endtask
    task t_en;
        pulse(14'h0001);
        @(posedge clk_in);
        enable_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        enable_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        ci(1'b0);
        rd_chk(8'h0C, 8'h00, 1);
        rd_chk(8'h0D, 8'h3E, 1);
        rd_chk(8'h0E, 8'h00, 1);
    endtask
    task final_report;
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Run is about two hundred cycles; ceiling leaves wide margin
    always @(posedge clk_in)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            fails = fails + 1;
            final_report;
        end
    end
    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        t_def;
        t_tx;
        t_rx;
        t_err;
        t_mask;
        t_col;
        t_nfc;
        t_proto;
        t_en;
        final_report;
    end
endmodule
